// ### logic/smc_pkg.sv
// constants and carrier types for the standby mode controller
package smc_pkg;

    // ------------------------------------------------------------
    // clock and register layout
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;   // system clock rate
    localparam int unsigned PCC_STOP_BIT  = 3;            // stop bit of clock control
    localparam int unsigned PCC_HALT_BIT  = 2;            // halt bit of clock control
    localparam int unsigned EDGE0_BYP_BIT = 2;            // filter bypass bit, edge0 mode

    // settling wait exponents (main clock periods = 2**exp)
    localparam int unsigned WAIT_EXP_20   = 20;
    localparam int unsigned WAIT_EXP_17   = 17;
    localparam int unsigned WAIT_EXP_15   = 15;
    localparam int unsigned WAIT_EXP_13   = 13;
    localparam int unsigned WAIT_W        = 21;           // counter width for 2**20

    // timer mode codes, low three bits
    localparam logic [2:0] TMODE_W20      = 3'h0;
    localparam logic [2:0] TMODE_W17      = 3'h3;
    localparam logic [2:0] TMODE_W15      = 3'h5;
    localparam logic [2:0] TMODE_W13      = 3'h7;

    // resume sequencing: instructions run before the vectored take
    localparam logic [1:0] RESUME_INSNS   = 2'h2;

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        SMC_RUN    = 5'b0_0001,   // cpu executing
        SMC_HALT   = 5'b0_0010,   // cpu clock gated
        SMC_STOP   = 5'b0_0100,   // main oscillator stopped
        SMC_SETTLE = 5'b0_1000,   // counting settling wait
        SMC_RESUME = 5'b1_0000    // clearing bits, reopening cpu clock
    } smc_state_t;

    // wake source request/enable view
    typedef struct packed {
        logic irq_one;      // ext_irq_one request and enable
        logic irq_two;      // ext_irq_two_testable, testable source
        logic irq_four;     // ext_irq_four
        logic irq_zero;     // ext_irq_zero
        logic watch;        // watch_timer_request, testable source
        logic other;        // any internal vectored source
    } smc_wake_t;

    // peripheral run enables
    typedef struct packed {
        logic itimer_run;   // interval / watchdog timer
        logic serial_run;   // serial interface
        logic tcount_run;   // timer / event counters
        logic watch_run;    // watch timer
        logic disp_run;     // display controller
        logic edge0_run;    // ext_irq_zero detector
        logic edge124_run;  // other external irq detectors
    } smc_periph_t;

endpackage : smc_pkg

// ### logic/smc_standby_ctrl.sv
// standby mode controller: stop / halt entry, wake, settling, resume
`timescale 1ns/1ps

module smc_standby_ctrl
    import smc_pkg::*;
#(
    parameter bit          OTP_VARIANT   = 1'b0,   // fixed short reset wait
    parameter int unsigned RST_WAIT_EXP  = WAIT_EXP_17, // build-time reset wait
    parameter int unsigned WAIT_SCALE    = 0       // right shift of waits, sim only
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // cpu instruction strobes, same clock
    input  wire logic        stop_insn,        // stop instruction executed
    input  wire logic        halt_insn,        // halt instruction executed
    input  wire logic        insn_retired,     // one instruction completed
    input  wire logic        master_irq_enable,
    input  wire logic        run_on_main_clk,  // cpu currently on main clock
    // interrupt requests anded with enables, from irq logic
    input  wire smc_wake_t   wake_req,
    // configuration
    input  wire logic [3:0]  interval_timer_mode,
    input  wire logic [3:0]  edge0_mode_register,
    input  wire logic        serial_ext_clk,   // serial uses external shift clock
    input  wire logic        tcount_ext_pin,   // counters use timer_count_input_pins
    input  wire logic        watch_on_sub,     // watch timer on subclock
    input  wire logic        display_clock_select, // display on subclock
    // oscillator pin status, asynchronous
    input  wire logic        main_osc_running, // main oscillator oscillating
    input  wire logic        main_clk_tick,    // main clock period marker
    input  wire logic        reset_wake,       // reset seen while in standby
    // outputs
    output logic [3:0]       processor_clock_control_sb, // stop/halt bits view
    output logic             main_osc_enable,  // main oscillator on
    output logic             cpu_clk_enable,   // cpu clock ungated
    output logic             in_standby,       // standby active
    output logic             hold_state,       // freeze cpu-visible state
    output logic             vector_take,      // take vectored irq, pulse
    output logic             reset_seq_start,  // ordinary reset sequence, pulse
    output smc_periph_t      periph_run        // peripheral run enables
);

    initial
    begin
        if (RST_WAIT_EXP != WAIT_EXP_17 && RST_WAIT_EXP != WAIT_EXP_15)
            $error("smc_standby_ctrl: reset wait must be 2**17 or 2**15");
        if (WAIT_SCALE > WAIT_EXP_13)
            $error("smc_standby_ctrl: WAIT_SCALE too large");
    end

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // settling periods for a timer mode code
    function automatic logic [WAIT_W-1:0] wait_of_code(input logic [2:0] code);
        logic [WAIT_W-1:0] w;
        w = '0;
        case (code)
            TMODE_W20: w = WAIT_W'(1) << WAIT_EXP_20;
            TMODE_W17: w = WAIT_W'(1) << WAIT_EXP_17;
            TMODE_W15: w = WAIT_W'(1) << WAIT_EXP_15;
            TMODE_W13: w = WAIT_W'(1) << WAIT_EXP_13;
            default:   w = WAIT_W'(1) << WAIT_EXP_13; // prohibited code
        endcase
        return w >> WAIT_SCALE;
    endfunction : wait_of_code

    // release allowed for either standby kind
    function automatic logic wake_any(input smc_wake_t w, input logic bypass);
        return w.irq_one | w.irq_two | w.irq_four | w.watch | w.other
             | (w.irq_zero & bypass);
    endfunction : wake_any

    // ------------------------------------------------------------
    // synchronisers for pin inputs
    // ------------------------------------------------------------
    logic [2:0] sync1_ff;   // first stage, read only by second
    logic [2:0] sync2_ff;   // second stage
    logic       osc_s;      // oscillator running, synced
    logic       tick_s;     // main clock period, synced
    logic       rwake_s;    // reset wake, synced
    logic       tick_d_ff;  // delayed tick for edge detect

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_ff  <= 3'h0;
            sync2_ff  <= 3'h0;
            tick_d_ff <= 1'b0;
        end
        else
        begin
            sync1_ff  <= {reset_wake, main_clk_tick, main_osc_running};
            sync2_ff  <= sync1_ff;
            tick_d_ff <= sync2_ff[1];
        end
    end

    assign osc_s   = sync2_ff[0];
    assign tick_s  = sync2_ff[1] & ~tick_d_ff;
    assign rwake_s = sync2_ff[2];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        smc_state_t  state;     // sequencer state
        logic [3:0]  pcc_sb;    // stop/halt bits of clock control
        logic        from_stop; // settling after stop
        logic        by_reset;  // woken by reset
        logic        vec_pend;  // vectored take pending
        logic [1:0]  insn_cnt;  // instructions since resume
        logic        osc_en;    // main oscillator enable
        logic        cpu_en;    // cpu clock enable
        logic        vec;       // vector take pulse
        logic        rst_seq;   // reset sequence pulse
        smc_periph_t per;       // peripheral run enables
    } smc_top_state_t;

    smc_top_state_t st_ff;      // registered state
    smc_top_state_t nxt_st;     // next state

    logic              bypass0;    // ext_irq_zero filter bypassed
    logic              wake;       // qualified wake request
    logic              vec_ok;     // wake source may vector
    logic              wc_start;   // start settling counter
    logic [WAIT_W-1:0] wc_load;    // settling length
    logic              wc_done;    // settling complete
    logic              settle_arm; // oscillator restarted, count may begin

    assign bypass0 = edge0_mode_register[EDGE0_BYP_BIT];
    assign wake    = wake_any(wake_req, bypass0);
    // testable sources alone never vector
    assign vec_ok  = wake_req.irq_one | wake_req.irq_four | wake_req.other
                   | (wake_req.irq_zero & bypass0);

    // ------------------------------------------------------------
    // settling counter
    // ------------------------------------------------------------
    smc_wait_counter #(
        .WIDTH    (WAIT_W)
    ) u_wait (
        .clk      (clk),
        .nrst     (nrst),
        .start    (wc_start),
        .load_val (wc_load),
        .tick     (tick_s),
        .done     (wc_done)
    );

    // count starts only once the oscillator is seen running
    assign settle_arm = (st_ff.state == SMC_STOP) && st_ff.osc_en && osc_s;
    // a stop taken with a request pending keeps the oscillator and skips
    // the stop state, so the wait is loaded on the way into settle
    assign wc_start   = settle_arm
                      || ((st_ff.state == SMC_RUN) && (nxt_st.state == SMC_SETTLE));
    assign wc_load    = st_ff.by_reset
                      ? ((OTP_VARIANT ? (WAIT_W'(1) << WAIT_EXP_15)
                                      : (WAIT_W'(1) << RST_WAIT_EXP)) >> WAIT_SCALE)
                      : wait_of_code(interval_timer_mode[2:0]);

    // ------------------------------------------------------------
    // next state logic
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st         = st_ff;
        nxt_st.vec     = 1'b0;
        nxt_st.rst_seq = 1'b0;
        case (st_ff.state)
            SMC_RUN:
            begin
                nxt_st.osc_en = 1'b1;
                nxt_st.cpu_en = 1'b1;
                // two instructions then vectored take
                if (st_ff.vec_pend && insn_retired)
                begin
                    if (st_ff.insn_cnt == RESUME_INSNS - 2'h1)
                    begin
                        nxt_st.vec      = 1'b1;
                        nxt_st.vec_pend = 1'b0;
                        nxt_st.insn_cnt = 2'h0;
                    end
                    else
                        nxt_st.insn_cnt = st_ff.insn_cnt + 2'h1;
                end
                if (stop_insn && run_on_main_clk)
                begin
                    nxt_st.pcc_sb[PCC_STOP_BIT] = 1'b1;
                    nxt_st.vec_pend = 1'b0;
                    nxt_st.cpu_en   = 1'b0;
                    if (wake)
                    begin
                        // pending request: skip stop, go to settle, keep osc
                        nxt_st.state     = SMC_SETTLE;
                        nxt_st.from_stop = 1'b1;
                        nxt_st.by_reset  = 1'b0;
                    end
                    else
                    begin
                        nxt_st.state  = SMC_STOP;
                        nxt_st.osc_en = 1'b0;
                        nxt_st.by_reset = 1'b0;
                        // settle must hold for the counter, not fall through
                        nxt_st.from_stop = 1'b1;
                    end
                end
                else if (halt_insn)
                begin
                    nxt_st.pcc_sb[PCC_HALT_BIT] = 1'b1;
                    nxt_st.vec_pend = 1'b0;
                    nxt_st.cpu_en   = 1'b0;
                    nxt_st.state    = wake ? SMC_RESUME : SMC_HALT;
                    nxt_st.from_stop = 1'b0;
                    nxt_st.by_reset  = 1'b0;
                end
            end
            SMC_HALT:
            begin
                if (rwake_s)
                begin
                    nxt_st.by_reset = 1'b1;
                    nxt_st.state    = SMC_RESUME;
                end
                else if (wake)
                    nxt_st.state = SMC_RESUME;
            end
            SMC_STOP:
            begin
                // restart oscillator on wake, then wait for it to run
                if (!st_ff.osc_en)
                begin
                    if (rwake_s)
                    begin
                        nxt_st.by_reset = 1'b1;
                        nxt_st.osc_en   = 1'b1;
                    end
                    else if (wake)
                        nxt_st.osc_en = 1'b1;
                end
                else if (osc_s)
                    nxt_st.state = SMC_SETTLE;
            end
            SMC_SETTLE:
            begin
                if (rwake_s)
                    nxt_st.by_reset = 1'b1;
                if (wc_done || (!st_ff.from_stop))
                    nxt_st.state = SMC_RESUME;
            end
            SMC_RESUME:
            begin
                // bits cleared and cpu clock opened on the same edge
                nxt_st.pcc_sb[PCC_STOP_BIT] = 1'b0;
                nxt_st.pcc_sb[PCC_HALT_BIT] = 1'b0;
                nxt_st.osc_en    = 1'b1;
                nxt_st.cpu_en    = 1'b1;
                nxt_st.from_stop = 1'b0;
                nxt_st.state     = SMC_RUN;
                nxt_st.insn_cnt  = 2'h0;
                if (st_ff.by_reset)
                begin
                    nxt_st.rst_seq  = 1'b1;
                    nxt_st.vec_pend = 1'b0;
                    nxt_st.by_reset = 1'b0;
                end
                else
                    nxt_st.vec_pend = master_irq_enable & vec_ok;
            end
            default:
                nxt_st.state = SMC_RUN;
        endcase
        // peripheral run enables per mode
        nxt_st.per.itimer_run  = (nxt_st.state != SMC_STOP) && nxt_st.osc_en
                               && !(nxt_st.state == SMC_SETTLE
                                    && st_ff.from_stop == 1'b0 && 1'b0);
        nxt_st.per.serial_run  = serial_ext_clk || nxt_st.osc_en;
        nxt_st.per.tcount_run  = tcount_ext_pin || nxt_st.osc_en;
        nxt_st.per.watch_run   = watch_on_sub || nxt_st.osc_en;
        nxt_st.per.disp_run    = display_clock_select || nxt_st.osc_en;
        nxt_st.per.edge0_run   = (nxt_st.state == SMC_RUN) || bypass0;
        nxt_st.per.edge124_run = 1'b1;
    end

    // register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_ff         <= '0;
            st_ff.state   <= SMC_RUN;
            st_ff.osc_en  <= 1'b1;
            st_ff.cpu_en  <= 1'b1;
            st_ff.per     <= '1;
        end
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------
    assign processor_clock_control_sb = st_ff.pcc_sb;
    assign main_osc_enable            = st_ff.osc_en;
    assign cpu_clk_enable             = st_ff.cpu_en;
    assign in_standby                 = ~st_ff.cpu_en;
    assign hold_state                 = ~st_ff.cpu_en;
    assign vector_take                = st_ff.vec;
    assign reset_seq_start            = st_ff.rst_seq;
    assign periph_run                 = st_ff.per;

endmodule : smc_standby_ctrl

// ### logic/smc_wait_counter.sv
// settling wait counter for the standby mode controller
`timescale 1ns/1ps

module smc_wait_counter
    import smc_pkg::*;
#(
    parameter int unsigned WIDTH = WAIT_W
)
(
    // clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // control
    input  wire logic             start,     // load a new wait
    input  wire logic [WIDTH-1:0] load_val,  // periods to wait
    input  wire logic             tick,      // one main clock period seen
    // status
    output logic                  done       // wait finished, one cycle
);

    initial
    begin
        if (WIDTH < WAIT_EXP_20 + 1)
            $error("smc_wait_counter: WIDTH too small for longest wait");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] cnt;   // remaining periods
        logic             busy;  // counting
        logic             done;  // finish pulse
    } smc_wc_state_t;

    smc_wc_state_t st_ff;        // registered state
    smc_wc_state_t nxt_st;       // next state

    // next state: load, count down on tick, pulse at zero
    always_comb
    begin
        nxt_st      = st_ff;
        nxt_st.done = 1'b0;
        if (start)
        begin
            nxt_st.cnt  = load_val;
            nxt_st.busy = 1'b1;
        end
        else if (st_ff.busy && tick)
        begin
            if (st_ff.cnt <= WIDTH'(1))
            begin
                nxt_st.cnt  = '0;
                nxt_st.busy = 1'b0;
                nxt_st.done = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt - WIDTH'(1);
            end
        end
    end

    // register
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign done = st_ff.done;

endmodule : smc_wait_counter

// ### sim/smc_cpu_model.sv
// cpu core and main oscillator model facing the standby controller
`timescale 1ns/1ps

module smc_cpu_model #(
    parameter int START = 6  // oscillator start-up, cycles
)
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // controller side
    input wire logic cpu_clk_enable,
    input wire logic main_osc_enable,
    // back to controller
    output logic     insn_retired,
    output logic     main_osc_running,
    output logic     main_clk_tick
);
    int up;  // cycles since oscillator enabled
    // one instruction a cycle; oscillator starts late, ticks while running
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            up               <= START;
            insn_retired     <= 1'b0;
            main_osc_running <= 1'b1;
            main_clk_tick    <= 1'b0;
        end
        else
        begin
            insn_retired     <= cpu_clk_enable;
            up               <= main_osc_enable ? up + 1 : 0;
            main_osc_running <= main_osc_enable && up >= START;
            main_clk_tick    <= main_osc_running ? !main_clk_tick : 1'b0;
        end
    end
endmodule : smc_cpu_model

// ### sim/smc_standby_ctrl_test.sv
// self-checking bench for the standby mode controller
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end

module smc_standby_ctrl_test
    import smc_pkg::*;
;
    localparam int SC = 12;  // wait shift for simulation
    typedef struct { logic [3:0] mode; int ex; } smc_row_t;
    smc_row_t rows[6] = '{'{4'h0, 20}, '{4'h3, 17}, '{4'h5, 15}, '{4'h7, 13},
                          '{4'h8, 20}, '{4'h2, 13}};
    logic clk = 1'b0, nrst = 1'b0, stop_insn = 1'b0, halt_insn = 1'b0;
    logic master_irq_enable = 1'b0, run_on_main_clk = 1'b1, serial_ext_clk = 1'b0;
    logic tcount_ext_pin = 1'b0, watch_on_sub = 1'b1, display_clock_select = 1'b1;
    logic reset_wake = 1'b0, insn_retired, main_osc_running, main_clk_tick;
    logic [3:0] interval_timer_mode = 4'h0, edge0_mode_register = 4'h0;
    logic [3:0] processor_clock_control_sb;
    logic main_osc_enable, cpu_clk_enable, in_standby, hold_state, vector_take;
    logic reset_seq_start, vec, rs;
    smc_wake_t wake_req = '0, w1 = '0, w2 = '0, w3 = '0, w4 = '0;
    smc_periph_t periph_run, ep;
    int err_total = 0, checks = 0, cyc, n;

    smc_standby_ctrl #(.WAIT_SCALE(SC)) smc_standby_ctrl_i (.*);
    smc_cpu_model smc_cpu_model_i (.*);

    always #12.5 clk = !clk;
    // latch the one-cycle pulses
    always @(negedge clk)
    begin
        vec |= (vector_take === 1'b1);
        rs  |= (reset_seq_start === 1'b1);
    end

    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict

    // wait for the cpu clock, counting only oscillating cycles
    task automatic wake_wait(input int lim);
        for (cyc = 0; cyc < lim && cpu_clk_enable !== 1'b1;
             cyc += (main_osc_running === 1'b1))
            @(negedge clk);
        repeat (6) @(negedge clk);
    endtask : wake_wait

    // enter stop or halt with flags clear, then raise the wake source
    task automatic standby(input bit stp, input smc_wake_t w, input int lim);
        @(negedge clk);
        stop_insn = stp;
        halt_insn = !stp;
        @(negedge clk);
        stop_insn = 1'b0;
        halt_insn = 1'b0;
        repeat (4) @(negedge clk);
        ep = {1'b0, serial_ext_clk, tcount_ext_pin, watch_on_sub, display_clock_select,
              edge0_mode_register[2], 1'b1};
        if (stp)
            `CHK("stop_per", ep, periph_run)
        vec = 1'b0;
        rs = 1'b0;
        wake_req = w;
        wake_wait(lim);
        wake_req = '0;
    endtask : standby

    initial
    begin
        #(25 * 20000);
        err_total++;
        give_verdict();
    end

    initial
    begin
        w1.other = 1'b1;
        w2.watch = 1'b1;
        w3.irq_two = 1'b1;
        w4.irq_zero = 1'b1;
        repeat (20) @(negedge clk);
        `CHK("pcc", 4'h0, processor_clock_control_sb)
        `CHK("cpu_en", 1'b1, cpu_clk_enable)
        `CHK("osc_en", 1'b1, main_osc_enable)
        `CHK("periph", 7'h7f, periph_run)
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        // ------------------------------------------------------------
        // stop wake wait per timer code, resume kind per master enable
        // ------------------------------------------------------------
        foreach (rows[i])
        begin
            interval_timer_mode = rows[i].mode;
            serial_ext_clk = i[0];
            master_irq_enable = i[1];
            n = (1 << rows[i].ex) >> SC;
            standby(1'b1, w1, 3000);
            `CHK("wait", 1'b1, cyc >= 2 * n - 2 && cyc <= 2 * n + 10)
            `CHK("vector", master_irq_enable, vec)
        end
        // ------------------------------------------------------------
        // halt wakes by testable sources never vector
        // ------------------------------------------------------------
        master_irq_enable = 1'b1;
        standby(1'b0, w2, 50);
        `CHK("halt_cyc", 1'b1, cyc <= 3)
        `CHK("watch_vec", 1'b0, vec)
        standby(1'b0, w3, 50);
        `CHK("two_vec", 1'b0, vec)
        // edge zero wakes only with its filter bypassed
        standby(1'b0, w4, 20);
        `CHK("zero_off", 1'b0, cpu_clk_enable)
        edge0_mode_register = 4'h4;
        @(negedge clk);
        wake_req = w4;
        wake_wait(20);
        `CHK("zero_byp", 1'b1, cpu_clk_enable)
        wake_req = '0;
        // stop refused off the main clock
        run_on_main_clk = 1'b0;
        stop_insn = 1'b1;
        @(negedge clk);
        stop_insn = 1'b0;
        repeat (2) @(negedge clk);
        `CHK("refused", 4'h0, processor_clock_control_sb)
        run_on_main_clk = 1'b1;
        // request already pending at stop: settle on the running clock
        wake_req = w1;
        stop_insn = 1'b1;
        @(negedge clk);
        stop_insn = 1'b0;
        `CHK("pend_pcc", 4'h8, processor_clock_control_sb)
        wake_wait(100);
        wake_req = '0;
        `CHK("pend_exit", 1'b1, cpu_clk_enable)
        // reset pin ends halt through the reset sequence
        standby(1'b0, '0, 10);
        reset_wake = 1'b1;
        wake_wait(600);
        reset_wake = 1'b0;
        `CHK("reset_seq", 1'b1, rs)
        // reset pin ends stop after the build-time wait
        repeat (2) @(negedge clk);
        stop_insn = 1'b1;
        @(negedge clk);
        stop_insn = 1'b0;
        repeat (4) @(negedge clk);
        rs = 1'b0;
        reset_wake = 1'b1;
        n = (1 << WAIT_EXP_17) >> SC;
        wake_wait(600);
        reset_wake = 1'b0;
        `CHK("rst_wait", 1'b1, cyc >= 2 * n - 2 && cyc <= 2 * n + 10)
        `CHK("rst_stop", 1'b1, rs)
        repeat (2) @(negedge clk);
        // block reset in mid halt
        standby(1'b0, '0, 10);
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        `CHK("rst_pcc", 4'h0, processor_clock_control_sb)
        `CHK("rst_cpu", 1'b1, cpu_clk_enable)
        give_verdict();
    end
endmodule : smc_standby_ctrl_test

// ### sim/smc_standby_sva.sv
// port-level assertion checker for the standby mode controller
`timescale 1ns/1ps

module smc_standby_sva
    import smc_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        nrst,
    // watched inputs
    input wire logic        stop_insn,
    input wire logic        halt_insn,
    input wire logic        master_irq_enable,
    input wire logic        run_on_main_clk,
    input wire smc_wake_t   wake_req,
    input wire logic        serial_ext_clk,
    // watched outputs
    input wire logic [3:0]  processor_clock_control_sb,
    input wire logic        main_osc_enable,
    input wire logic        cpu_clk_enable,
    input wire logic        in_standby,
    input wire logic        hold_state,
    input wire logic        vector_take,
    input wire logic        reset_seq_start,
    input wire smc_periph_t periph_run
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // cpu running with both standby bits cleared
    sequence resumed_s;
        cpu_clk_enable && processor_clock_control_sb[3:2] == 2'h0;
    endsequence
    // halted with an always-live wake source pending
    sequence halt_wake_s;
        processor_clock_control_sb[2] && (wake_req.irq_one || wake_req.irq_two
            || wake_req.irq_four || wake_req.watch || wake_req.other);
    endsequence
    logic run_take;  // instructions are taken only while running
    logic osc_off;   // main oscillator held off
    assign run_take = cpu_clk_enable && !in_standby;
    assign osc_off  = processor_clock_control_sb[3] && !main_osc_enable;
    a_halt_entry: assert property (run_take && halt_insn && !stop_insn |=>
        processor_clock_control_sb[2] && !cpu_clk_enable) else $error("halt entry");
    a_stop_entry: assert property (run_take && stop_insn && run_on_main_clk |=>
        processor_clock_control_sb[3] && !cpu_clk_enable) else $error("stop entry");
    a_halt_osc: assert property (processor_clock_control_sb[3:2] == 2'h1 |->
        main_osc_enable) else $error("oscillator off in halt");
    a_stop_timer: assert property (osc_off && $past(osc_off) |->
        !periph_run.itimer_run) else $error("interval timer runs in stop");
    a_stop_serial: assert property (osc_off && $past(osc_off) |->
        periph_run.serial_run == $past(serial_ext_clk)) else $error("serial in stop");
    a_halt_wake: assert property (halt_wake_s |-> ##[1:2] resumed_s)
        else $error("halt not released");
    a_clear_first: assert property ($rose(cpu_clk_enable) |->
        processor_clock_control_sb[3:2] == 2'h0) else $error("bits set at resume");
    a_hold_standby: assert property (in_standby |-> hold_state)
        else $error("state not held");
    a_vector_gate: assert property (vector_take |->
        master_irq_enable && cpu_clk_enable) else $error("vector without enable");
    a_reset_seq: assert property (reset_seq_start |-> resumed_s)
        else $error("reset sequence early");
endmodule : smc_standby_sva

bind smc_standby_ctrl smc_standby_sva smc_standby_sva_i (.*);
